//--- dscl_pkg.sv
// Constants and types shared by the dual switch control logic
package dscl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int BULB_STEP_US = 25;
  localparam int MOTOR_STEP_US = 100;
  localparam int RETRY_US = 150;
  localparam int FRAME_BITS = 16;

  // ----------------------------------------------------------------
  // Serial frame addresses, frame[15:12]
  // ----------------------------------------------------------------
  localparam logic [3:0] SPI_NOP = 4'h0;
  localparam logic [3:0] SPI_CH0 = 4'h1;
  localparam logic [3:0] SPI_CH1 = 4'h2;
  localparam logic [3:0] SPI_GLB = 4'h3;
  localparam logic [3:0] SPI_CLR = 4'h4;

  // ----------------------------------------------------------------
  // APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_CFG0 = 8'h08;
  localparam logic [7:0] A_CFG1 = 8'h0c;
  localparam logic [7:0] A_GLB = 8'h10;
  localparam logic CTRL_WD_EN_RST = 1'b1;
  localparam logic [18:0] SYNC_RST = 19'h00003;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_DIRECT = 2'b00,
    SRC_EXT = 2'b01,
    SRC_INT = 2'b10,
    SRC_SPI = 2'b11
  } dscl_src_t;

  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_FAILSAFE = 2'b10
  } dscl_mode_t;

  typedef struct packed {
    dscl_src_t src;
    logic spi_on;
    logic [3:0] duty;
    logic [1:0] slew;
    logic [1:0] retry_lim;
  } dscl_ch_cfg_t;

  typedef struct packed {
    logic [1:0] ratio;
    logic temp;
    logic chan;
  } dscl_glb_t;

  typedef struct packed {
    logic ol_on;
    logic ol_off;
    logic ot;
    logic sc;
    logic oc;
  } dscl_flt_t;

endpackage : dscl_pkg

//--- dscl_spi_if.sv
// Signals between the control core and its serial port
`timescale 1ns/1ps
interface dscl_spi_if;
  logic sclk;
  logic si;
  logic cs_n;
  logic so;
  logic so_oe;
  logic frame_valid;
  logic [15:0] frame;
  logic [15:0] status;

  modport port (
    input sclk,
    input si,
    input cs_n,
    input status,
    output so,
    output so_oe,
    output frame,
    output frame_valid
  );

  modport core (
    output sclk,
    output si,
    output cs_n,
    output status,
    input so,
    input so_oe,
    input frame,
    input frame_valid
  );
endinterface : dscl_spi_if

//--- dscl_spi.sv
// Serial frame shifter with daisy-chain output
`timescale 1ns/1ps
module dscl_spi (
  input wire logic clk,
  input wire logic rst_n,
  dscl_spi_if.port bus
);

  typedef struct packed {
    logic sclk_q;
    logic cs_q;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic so;
    logic so_oe;
    logic fv;
    logic [15:0] frame;
  } dscl_spi_st_t;

  dscl_spi_st_t st;
  dscl_spi_st_t next_st;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.fv = 1'b0;
    next_st.sclk_q = bus.sclk;
    next_st.cs_q = bus.cs_n;
    next_st.so_oe = !bus.cs_n;
    if (st.cs_q && !bus.cs_n) begin
      next_st.sh = bus.status;
      next_st.cnt = 5'h00;
      next_st.so = bus.status[15];
    end else if (!bus.cs_n) begin
      if (bus.sclk && !st.sclk_q) begin
        next_st.sh = {st.sh[14:0], bus.si};
        if (st.cnt != 5'h1f) begin
          next_st.cnt = st.cnt + 5'h01;
        end
      end
      if (!bus.sclk && st.sclk_q) begin
        next_st.so = st.sh[15];
      end
    end else if (!st.cs_q &&
        st.cnt == 5'(dscl_pkg::FRAME_BITS)) begin
      next_st.fv = 1'b1;
      next_st.frame = st.sh;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cs_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign bus.so = st.so;
  assign bus.so_oe = st.so_oe;
  assign bus.frame = st.frame;
  assign bus.frame_valid = st.fv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_FRAME_16: assert property (
    st.fv |-> $past(st.cnt) == 5'h10 && $past(bus.cs_n))
    else $error("frame accepted with wrong bit count");
  AST_SO_ONLY_SELECTED: assert property (
    st.so_oe == !$past(bus.cs_n))
    else $error("serial out enable not tied to select");

endmodule : dscl_spi

//--- dscl_top.sv
// Dual switch control, protection and supervision logic
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module dscl_top #(
  parameter int WD_TIMEOUT_US = 1000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic [1:0] direct_in,
  input wire logic ext_clock,
  input wire logic [1:0] profile_sel,
  input wire logic [1:0] oc_det,
  input wire logic [1:0] sc_det,
  input wire logic [1:0] ot_det,
  input wire logic [1:0] ol_off_det,
  input wire logic [1:0] ol_on_det,
  output logic [1:0] load_output,
  output logic [3:0] oc_level,
  output logic [3:0] slew_sel,
  output logic sense_temp_sel,
  output logic sense_chan_sel,
  output logic [1:0] sense_ratio,
  output logic sense_valid_n,
  output logic fault_flag_n,
  output logic fail_safe_flag_n,
  output logic sleep_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  if (WD_TIMEOUT_US < 1 || WD_TIMEOUT_US > 65535) begin : g_chk
    $error("WD_TIMEOUT_US out of range");
  end

  typedef struct packed {
    dscl_pkg::dscl_mode_t mode;
    logic [15:0] wd;
    logic [7:0] tick;
    logic ext_q;
    logic wd_en;
    dscl_pkg::dscl_ch_cfg_t [1:0] cfg;
    dscl_pkg::dscl_glb_t glb;
    logic [1:0][3:0] pwm;
    logic [1:0][7:0] age;
    logic [1:0] lat;
    logic [1:0][1:0] tries;
    logic [1:0][7:0] rtmr;
    dscl_pkg::dscl_flt_t [1:0] flt;
    logic [1:0] load;
    logic [3:0] lvl;
    logic svalid_n;
    logic fault_n;
    logic fs_n;
    logic sleep;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dscl_st_t;

  dscl_st_t st;
  dscl_st_t next_st;
  logic rst_q1;
  logic rst_n;
  logic [18:0] meta;
  logic [18:0] sy;
  dscl_spi_if spi ();

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= dscl_pkg::SYNC_RST;
      sy <= dscl_pkg::SYNC_RST;
    end else begin
      meta <= {ol_on_det, ol_off_det, ot_det, sc_det, oc_det,
        profile_sel, direct_in, ext_clock, si, sclk, chip_select_n,
        reset_n};
      sy <= meta;
    end
  end

  wire rst_pin_s = sy[0];
  wire ext_s = sy[4];
  wire [1:0] in_s = sy[6:5];
  wire [1:0] prof_s = sy[8:7];
  wire [1:0] oc_s = sy[10:9];
  wire [1:0] sc_s = sy[12:11];
  wire [1:0] ot_s = sy[14:13];
  wire [1:0] olf_s = sy[16:15];
  wire [1:0] oln_s = sy[18:17];

  assign spi.cs_n = sy[1];
  assign spi.sclk = sy[2];
  assign spi.si = sy[3];
  assign spi.status = {st.mode == dscl_pkg::MODE_FAILSAFE,
    st.mode == dscl_pkg::MODE_SLEEP, st.lat, st.flt[1], st.flt[0],
    st.load};

  dscl_spi u_spi (
    .clk(clk),
    .rst_n(rst_n),
    .bus(spi)
  );

  // ----------------------------------------------------------------
  // Control core
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic fv;
    logic [3:0] addr;
    logic [1:0] clr;
    logic [7:0] step;
    logic [1:0] lvl;
    logic req;
    logic oc_hit;
    logic trip;
    dscl_pkg::dscl_src_t src;
    tick = st.tick == 8'(dscl_pkg::TICK_CYC - 1);
    fv = spi.frame_valid;
    addr = spi.frame[15:12];
    clr = 2'b00;
    step = 8'h00;
    lvl = 2'b00;
    req = 1'b0;
    oc_hit = 1'b0;
    trip = 1'b0;
    src = dscl_pkg::SRC_DIRECT;
    next_st = st;
    next_st.tick = tick ? 8'h00 : st.tick + 8'h01;
    next_st.ext_q = ext_s;

    unique case (st.mode)
      dscl_pkg::MODE_SLEEP: begin
        if (|in_s || fv) begin
          next_st.mode = dscl_pkg::MODE_NORMAL;
        end
      end
      dscl_pkg::MODE_NORMAL: begin
        if (st.wd_en && tick && !fv &&
            st.wd == 16'(WD_TIMEOUT_US - 1)) begin
          next_st.mode = dscl_pkg::MODE_FAILSAFE;
        end
      end
      dscl_pkg::MODE_FAILSAFE: begin
        if (fv) begin
          next_st.mode = dscl_pkg::MODE_NORMAL;
        end
      end
      default: next_st.mode = dscl_pkg::MODE_SLEEP;
    endcase
    if (fv || st.mode != dscl_pkg::MODE_NORMAL || !st.wd_en) begin
      next_st.wd = 16'h0000;
    end else if (tick) begin
      next_st.wd = st.wd + 16'h0001;
    end

    if (fv) begin
      unique case (addr)
        dscl_pkg::SPI_CH0: next_st.cfg[0] = spi.frame[10:0];
        dscl_pkg::SPI_CH1: next_st.cfg[1] = spi.frame[10:0];
        dscl_pkg::SPI_GLB: next_st.glb = spi.frame[3:0];
        dscl_pkg::SPI_CLR: clr = spi.frame[1:0];
        default: clr = 2'b00;
      endcase
    end

    for (int c = 0; c < 2; c++) begin
      src = st.mode == dscl_pkg::MODE_FAILSAFE ?
        dscl_pkg::SRC_DIRECT : st.cfg[c].src;
      if ((src == dscl_pkg::SRC_EXT && ext_s && !st.ext_q) ||
          (src == dscl_pkg::SRC_INT && tick)) begin
        next_st.pwm[c] = st.pwm[c] + 4'h1;
      end
      unique case (src)
        dscl_pkg::SRC_DIRECT: req = in_s[c];
        dscl_pkg::SRC_EXT: req = st.pwm[c] < st.cfg[c].duty;
        dscl_pkg::SRC_INT: req = st.pwm[c] < st.cfg[c].duty;
        dscl_pkg::SRC_SPI: req = st.cfg[c].spi_on;
      endcase
      next_st.load[c] = req && !st.lat[c] &&
        st.mode != dscl_pkg::MODE_SLEEP;

      if (!st.load[c]) begin
        next_st.age[c] = 8'h00;
      end else if (tick && st.age[c] != 8'hff) begin
        next_st.age[c] = st.age[c] + 8'h01;
      end
      step = prof_s[c] ? 8'(dscl_pkg::MOTOR_STEP_US) :
        8'(dscl_pkg::BULB_STEP_US);
      lvl = st.age[c] < step ? 2'h2 :
        (st.age[c] < {step[6:0], 1'b0} ? 2'h1 : 2'h0);
      next_st.lvl[2*c +: 2] = next_st.age[c] < step ? 2'h2 :
        (next_st.age[c] < {step[6:0], 1'b0} ? 2'h1 : 2'h0);

      oc_hit = st.load[c] && oc_s[c] && (!prof_s[c] || lvl != 2'h2);
      trip = oc_hit || (st.load[c] && (sc_s[c] || ot_s[c]));
      // open load both states; set wins over clear
      next_st.flt[c] = clr[c] ? '0 : st.flt[c];
      next_st.flt[c] = next_st.flt[c] | {oln_s[c] && st.load[c],
        olf_s[c] && !st.load[c], st.load[c] && ot_s[c],
        st.load[c] && sc_s[c], oc_hit};

      if (clr[c]) begin
        next_st.lat[c] = 1'b0;
        next_st.tries[c] = 2'h0;
        next_st.rtmr[c] = 8'h00;
      end
      if (trip) begin
        next_st.lat[c] = 1'b1;
        next_st.rtmr[c] = 8'h00;
      end else if (st.lat[c] && !clr[c] &&
          st.tries[c] < st.cfg[c].retry_lim && tick) begin
        if (st.rtmr[c] == 8'(dscl_pkg::RETRY_US - 1)) begin
          next_st.lat[c] = 1'b0;
          next_st.rtmr[c] = 8'h00;
          next_st.tries[c] = st.tries[c] + 2'h1;
        end else begin
          next_st.rtmr[c] = st.rtmr[c] + 8'h01;
        end
      end
    end

    // reset pin clears config and faults
    if (!rst_pin_s) begin
      next_st.cfg = '0;
      next_st.glb = '0;
      next_st.lat = 2'b00;
      next_st.flt = '0;
      next_st.tries = '0;
      next_st.rtmr = '0;
      next_st.load = 2'b00;
      next_st.age = '0;
      next_st.lvl = 4'ha;
      next_st.mode = dscl_pkg::MODE_SLEEP;
    end

    next_st.svalid_n = !(next_st.glb.temp ||
      (next_st.load[next_st.glb.chan] &&
      next_st.lvl[2*next_st.glb.chan +: 2] == 2'h0));
    next_st.fault_n = !(|next_st.lat || |next_st.flt);
    next_st.fs_n = next_st.mode != dscl_pkg::MODE_FAILSAFE;
    next_st.sleep = next_st.mode == dscl_pkg::MODE_SLEEP;

    // APB slave, one wait state
    next_st.pready = psel && penable && !st.pready;
    if (psel && penable && !st.pready) begin
      next_st.pslverr = 1'b0;
      unique case (paddr)
        dscl_pkg::A_STATUS: next_st.prdata = {16'h0000, spi.status};
        dscl_pkg::A_CTRL: next_st.prdata = {31'h0, st.wd_en};
        dscl_pkg::A_CFG0: next_st.prdata = {21'h0, st.cfg[0]};
        dscl_pkg::A_CFG1: next_st.prdata = {21'h0, st.cfg[1]};
        dscl_pkg::A_GLB: next_st.prdata = {28'h0, st.glb};
        default: begin
          next_st.prdata = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st.pready && pwrite && !st.pslverr &&
        paddr == dscl_pkg::A_CTRL) begin
      next_st.wd_en = pwdata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.wd_en <= dscl_pkg::CTRL_WD_EN_RST;
      st.lvl <= 4'ha;
      st.svalid_n <= 1'b1;
      st.fault_n <= 1'b1;
      st.fs_n <= 1'b1;
      st.sleep <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign so = spi.so;
  assign so_oe = spi.so_oe;
  assign load_output = st.load;
  assign oc_level = st.lvl;
  assign slew_sel = {st.cfg[1].slew, st.cfg[0].slew};
  assign sense_temp_sel = st.glb.temp;
  assign sense_chan_sel = st.glb.chan;
  assign sense_ratio = st.glb.ratio;
  assign sense_valid_n = st.svalid_n;
  assign fault_flag_n = st.fault_n;
  assign fail_safe_flag_n = st.fs_n;
  assign sleep_mode = st.sleep;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  wire fv_wd_end = st.wd_en && !spi.frame_valid &&
    st.tick == 8'(dscl_pkg::TICK_CYC - 1) &&
    st.wd == 16'(WD_TIMEOUT_US - 1);

  AST_FAILSAFE_DIRECT: assert property (
    !fail_safe_flag_n && rst_pin_s && !st.lat[0]
    |=> load_output[0] == $past(in_s[0]))
    else $error("fail-safe channel ignores direct input");
  AST_FS_FLAG: assert property (
    st.mode == dscl_pkg::MODE_NORMAL && fv_wd_end && rst_pin_s
    |=> !fail_safe_flag_n)
    else $error("fail-safe flag not driven low");
  AST_FAULT_FLAG: assert property (
    (st.lat[0] || st.lat[1]) |-> !fault_flag_n)
    else $error("latched fault without fault flag");
  AST_RESET_PIN: assert property (
    !rst_pin_s |=> st.cfg == '0 && st.lat == 2'b00 && sleep_mode)
    else $error("reset pin did not clear state");
  AST_SLEEP_OFF: assert property (
    sleep_mode |-> load_output == 2'b00)
    else $error("output on during sleep");
  AST_INRUSH_LEVEL: assert property (
    !load_output[0] && rst_pin_s |=> oc_level[1:0] == 2'h2)
    else $error("threshold not at inrush level");
  AST_NO_RETRY: assert property (
    st.lat[0] && st.cfg[0].retry_lim == 2'h0 && !spi.frame_valid
    && rst_pin_s |=> st.lat[0])
    else $error("retry with retry disabled");
  AST_CFG_BY_FRAME: assert property (
    $changed(st.cfg) |-> $past(spi.frame_valid) || !$past(rst_pin_s))
    else $error("config changed without frame");

  COV_FAILSAFE: cover property (!fail_safe_flag_n);
  COV_TRIP: cover property ($rose(st.lat[0]));
  COV_RETRY: cover property ($fell(st.lat[1]) && !$past(spi.frame_valid));
  COV_FRAME: cover property (spi.frame_valid);

endmodule : dscl_top

//--- dscl_host_model.sv
// Serial bus host model that frames traffic into the switch logic
`timescale 1ns/1ps
module dscl_host_model (
  output logic chip_select_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  // ------------------------------------------------------------------
  // Frame driver
  // ------------------------------------------------------------------
  // Half period 32 ns gives the 64 ns link clock of the bench
  localparam time HALF = 32ns;

  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // MSB first, clock well inside what the sampler resolves
  // Clock stays low outside frames; n other than 16 is a refused frame
  // Non-blocking so edges that meet a clk edge cause no race
  task automatic xfer(input int n, input logic [31:0] tx,
      output logic [31:0] rx);
    rx = 32'h0;
    chip_select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      #HALF sclk <= 1'b1;
      rx = {rx[30:0], so};
      #HALF sclk <= 1'b0;
    end
    #HALF chip_select_n <= 1'b1;
    // Released input falls to its pull-down level
    si <= 1'b0;
    #(8 * HALF);
  endtask : xfer
endmodule : dscl_host_model

//--- testbench.sv
// Self-checking bench for the dual switch control logic
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reset_n = 1'b1;
  logic [1:0] direct_in = 2'b00;
  logic ext_clock = 1'b0;
  logic [1:0] profile_sel = 2'b00;
  logic [1:0] oc_det = 2'b00;
  logic [1:0] sc_det = 2'b00;
  logic [1:0] ot_det = 2'b00;
  logic [1:0] ol_off_det = 2'b00;
  logic [1:0] ol_on_det = 2'b00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire chip_select_n, sclk, si, so, so_oe;
  wire [1:0] load_output, sense_ratio;
  wire [3:0] oc_level, slew_sel;
  wire sense_temp_sel, sense_chan_sel, sense_valid_n;
  wire fault_flag_n, fail_safe_flag_n, sleep_mode, pready, pslverr;
  wire [31:0] prdata;
  // Deselected output shows the inverse, so a late enable is caught
  wire so_line = so_oe ? so : !so;
  logic [31:0] rd, rx;
  logic err;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int on0, on1;

  always #2.5 clk = ~clk;

  // Watchdog shortened to 5 us so fail-safe is reachable quickly
  dscl_top #(.WD_TIMEOUT_US(5)) i_dut (
    .clk, .nrst, .reset_n, .chip_select_n, .sclk, .si, .so, .so_oe,
    .direct_in, .ext_clock, .profile_sel, .oc_det, .sc_det,
    .ot_det, .ol_off_det, .ol_on_det,
    .load_output, .oc_level, .slew_sel, .sense_temp_sel, .sense_chan_sel,
    .sense_ratio, .sense_valid_n, .fault_flag_n, .fail_safe_flag_n,
    .sleep_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr
  );

  dscl_host_model i_host (.chip_select_n, .sclk, .si, .so(so_line));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Hang guard, well above the expected 25k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      close_out();
    end
  end

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk({load_output, fault_flag_n, fail_safe_flag_n, sleep_mode},
      5'h07);
    chk(oc_level, 4'ha);
    chk(so_oe, 1'b0);
    apb(1'b0, dscl_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // Watchdog off until the fail-safe test
    apb(1'b1, dscl_pkg::A_CTRL, 32'h0);
    apb(1'b0, dscl_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    direct_in <= 2'b01;
    repeat (20) @(posedge clk);
    chk({load_output, sleep_mode}, 3'b010);
    direct_in <= 2'b00;
    repeat (20) @(posedge clk);
    chk(load_output, 2'b00);
    $display("test direct done");
    // short frame refused, full frame applied
    i_host.xfer(15, 32'h0f0c, rx);
    chk(slew_sel, 4'h0);
    i_host.xfer(16, 32'h1708, rx);
    chk({slew_sel, load_output}, 6'h09);
    apb(1'b0, dscl_pkg::A_CFG0, 32'h0);
    chk(rd, 32'h708);
    i_host.xfer(16, 32'h300b, rx);
    chk({rx[15:14], rx[1:0]}, 4'h1);
    chk({sense_ratio, sense_temp_sel, sense_chan_sel}, 4'hb);
    chk(sense_valid_n, 1'b0);
    apb(1'b0, dscl_pkg::A_GLB, 32'h0);
    chk(rd, 32'hb);
    // daisy chain passes input after the status word
    i_host.xfer(32, 32'ha5c30000, rx);
    chk(rx[15:0], 16'ha5c3);
    $display("test serial done");
    // short circuit latches, clear frame, reset pin clears
    @(posedge clk);
    sc_det <= 2'b01;
    repeat (20) @(posedge clk);
    chk({fault_flag_n, load_output[0]}, 2'b00);
    sc_det <= 2'b00;
    apb(1'b0, dscl_pkg::A_STATUS, 32'h0);
    chk(rd, 32'h1008);
    i_host.xfer(16, 32'h4001, rx);
    chk({fault_flag_n, load_output[0]}, 2'b11);
    @(posedge clk);
    ot_det <= 2'b01;
    repeat (20) @(posedge clk);
    chk({fault_flag_n, load_output[0]}, 2'b00);
    ot_det <= 2'b00;
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({load_output, fault_flag_n, sleep_mode, slew_sel}, 8'h30);
    ol_off_det <= 2'b10;
    repeat (20) @(posedge clk);
    ol_off_det <= 2'b00;
    apb(1'b0, dscl_pkg::A_STATUS, 32'h0);
    chk(rd, 32'h4400);
    chk(fault_flag_n, 1'b0);
    i_host.xfer(16, 32'h4002, rx);
    chk(fault_flag_n, 1'b1);
    $display("test fault done");
    // bulb 25 us steps, motor 100 us steps
    @(posedge clk);
    profile_sel <= 2'b10;
    direct_in <= 2'b11;
    repeat (6000) @(posedge clk);
    chk(oc_level, 4'h9);
    oc_det <= 2'b10;
    ol_on_det <= 2'b01;
    repeat (20) @(posedge clk);
    chk(load_output, 2'b11);
    oc_det <= 2'b00;
    ol_on_det <= 2'b00;
    apb(1'b0, dscl_pkg::A_STATUS, 32'h0);
    chk(rd, 32'h0043);
    repeat (6000) @(posedge clk);
    chk(oc_level, 4'h8);
    direct_in <= 2'b00;
    $display("test profile done");
    // internal and external PWM at half duty
    i_host.xfer(16, 32'h1480, rx);
    i_host.xfer(16, 32'h2280, rx);
    on0 = 0;
    on1 = 0;
    for (int i = 0; i < 8000; i++) begin
      @(posedge clk);
      ext_clock <= i[5];
      on0 += load_output[0];
      on1 += load_output[1];
    end
    chk(on0 > 2000 && on0 < 6000, 1'b1);
    chk(on1 > 2000 && on1 < 6000, 1'b1);
    $display("test pwm done");
    apb(1'b1, dscl_pkg::A_CTRL, 32'h1);
    repeat (1500) @(posedge clk);
    chk(fail_safe_flag_n, 1'b0);
    direct_in <= 2'b10;
    repeat (20) @(posedge clk);
    chk(load_output, 2'b10);
    i_host.xfer(16, 32'h0, rx);
    chk(fail_safe_flag_n, 1'b1);
    $display("test fail-safe done");
    close_out();
  end
endmodule : testbench
